// [hdl/pcm_pkg.sv]
package pcm_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses, one aligned word each)
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_PIN_LEVELS = 8'h00;
    localparam logic [7:0] ADDR_LATCH      = 8'h04;
    localparam logic [7:0] ADDR_DIRECTION  = 8'h08;
    localparam logic [7:0] ADDR_USB_CTRL   = 8'h0c;
    localparam logic [7:0] ADDR_PERIPH     = 8'h10;

    // ------------------------------------------------------------
    // Field layout
    // ------------------------------------------------------------
    // Implemented bits of latch and direction: 7,6,2,1,0
    localparam logic [7:0] LAT_DIR_MASK    = 8'hc7;
    // Implemented bits of the pin-level register: all but bit 3
    localparam logic [7:0] PIN_LEVEL_MASK  = 8'hf7;
    // USB control: bits 6..1 implemented
    localparam logic [7:0] USB_CTRL_MASK   = 8'h7e;
    localparam int         USB_EN_BIT      = 3;

    // Peripheral enable register fields
    localparam int         PER_OSC_EN      = 0;
    localparam int         PER_CCP_EN      = 1;
    localparam int         PER_EXT_XCVR    = 2;
    localparam int         PER_XCVR_OFF    = 3;
    localparam int         PER_SER_EN      = 4;
    localparam int         PER_SER_SYNC    = 5;
    localparam logic [7:0] PERIPH_MASK     = 8'h3f;
    // Transceiver disable set at reset: on-chip transceiver is off
    localparam logic [7:0] PERIPH_RESET    = 8'h08;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] LATCH_RESET     = 8'h00;
    localparam logic [7:0] DIR_RESET       = 8'hc7;
    localparam logic [7:0] USB_CTRL_RESET  = 8'h00;

    // Pin indices
    localparam int         PIN_OSC_OUT     = 0;
    localparam int         PIN_OSC_IN      = 1;
    localparam int         PIN_CCP         = 2;
    localparam int         PIN_ABSENT      = 3;
    localparam int         PIN_DMINUS      = 4;
    localparam int         PIN_DPLUS       = 5;
    localparam int         PIN_SER_TX      = 6;
    localparam int         PIN_SER_RX      = 7;

endpackage

// [hdl/pcm_sync2.sv]
`timescale 1ns/1ps
module pcm_sync2 (
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    // Data
    input  wire logic [7:0] d_i,
    output logic      [7:0] q_o
);

    logic [7:0] meta_ff;
    logic [7:0] q_ff;

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            meta_ff <= 8'h00;
            q_ff    <= 8'h00;
        end
        else
        begin
            meta_ff <= d_i;
            q_ff    <= meta_ff;
        end
    end

    assign q_o = q_ff;

endmodule

// [hdl/pcm_port_c.sv]
// The APB interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module pcm_port_c (
    // Clock and reset
    input  wire logic        CLK_I,
    input  wire logic        RST_N_I,
    // APB slave
    input  wire logic        PSEL_I,
    input  wire logic        PENABLE_I,
    input  wire logic        PWRITE_I,
    input  wire logic [7:0]  PADDR_I,
    input  wire logic [31:0] PWDATA_I,
    output logic      [31:0] PRDATA_O,
    output logic             PREADY_O,
    output logic             PSLVERR_O,
    // Pins
    input  wire logic [7:0]  PIN_I,
    output logic      [7:0]  PIN_O,
    output logic      [7:0]  PIN_OE_O,
    // Peripheral side
    input  wire logic        CCP_OUT_I,
    input  wire logic        SER_TX_I,
    input  wire logic        SER_CLK_OUT_I,
    input  wire logic        SER_DATA_OUT_I,
    input  wire logic        SER_DATA_OE_I,
    input  wire logic        XCVR_OE_N_I,
    input  wire logic        USB_DM_OUT_I,
    input  wire logic        USB_DP_OUT_I,
    input  wire logic        USB_DRIVE_I,
    output logic             OSC_ENABLE_O,
    output logic             TIMER_COUNT_O,
    output logic             CCP_CAPTURE_O,
    output logic             SER_RX_O,
    output logic             SER_CLK_IN_O,
    output logic             USB_DM_IN_O,
    output logic             USB_DP_IN_O
);

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0]  latch_ff;
    logic [7:0]  dir_ff;
    logic [7:0]  usb_ctrl_ff;
    logic [7:0]  periph_ff;
    logic [31:0] rdata_ff;
    logic        ready_ff;
    logic        slverr_ff;
    logic [7:0]  pin_o_ff;
    logic [7:0]  pin_oe_ff;
    logic        osc_enable_ff;
    logic        timer_count_ff;
    logic        ccp_capture_ff;
    logic        ser_rx_ff;
    logic        ser_clk_in_ff;
    logic        usb_dm_in_ff;
    logic        usb_dp_in_ff;
    logic [7:0]  pin_sync;

    // ------------------------------------------------------------
    // Pin input synchroniser
    // ------------------------------------------------------------
    pcm_sync2 u_sync (
        .clk_i   (CLK_I),
        .rst_n_i (RST_N_I),
        .d_i     (PIN_I),
        .q_o     (pin_sync)
    );

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // One aligned word per register, so a full byte compare selects
    function automatic logic addr_hit(
        input logic [7:0] addr,
        input logic [7:0] reg_addr
    );
        return addr == reg_addr;
    endfunction

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    wire        setup     = PSEL_I && !PENABLE_I;
    wire        sel_pins  = addr_hit(PADDR_I, pcm_pkg::ADDR_PIN_LEVELS);
    wire        sel_latch = addr_hit(PADDR_I, pcm_pkg::ADDR_LATCH);
    wire        sel_dir   = addr_hit(PADDR_I, pcm_pkg::ADDR_DIRECTION);
    wire        sel_usb   = addr_hit(PADDR_I, pcm_pkg::ADDR_USB_CTRL);
    wire        sel_per   = addr_hit(PADDR_I, pcm_pkg::ADDR_PERIPH);
    wire        mapped    = sel_pins | sel_latch | sel_dir | sel_usb
                          | sel_per;
    wire        access    = PSEL_I && PENABLE_I;
    wire        wr_en     = access && PWRITE_I && ready_ff && mapped;
    wire [7:0]  wdat      = PWDATA_I[7:0];

    // ------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------
    wire osc_en   = periph_ff[pcm_pkg::PER_OSC_EN];
    wire ccp_en   = periph_ff[pcm_pkg::PER_CCP_EN];
    wire ext_xcvr = periph_ff[pcm_pkg::PER_EXT_XCVR];
    wire xcvr_on  = !periph_ff[pcm_pkg::PER_XCVR_OFF];
    wire ser_en   = periph_ff[pcm_pkg::PER_SER_EN];
    wire ser_sync = periph_ff[pcm_pkg::PER_SER_SYNC];
    wire usb_en   = usb_ctrl_ff[pcm_pkg::USB_EN_BIT];
    wire ser_async = ser_en && !ser_sync;
    wire ser_syncm = ser_en && ser_sync;

    // Pins 4 and 5 are port inputs only with USB and transceiver off
    wire usb_pins_port = !usb_en && !xcvr_on;
    wire int_xcvr_act  = usb_en && xcvr_on && !ext_xcvr;
    wire usb_drive     = int_xcvr_act && USB_DRIVE_I;

    // ------------------------------------------------------------
    // Pin drive selection
    // ------------------------------------------------------------
    logic [7:0] nxt_pin_o;
    logic [7:0] nxt_pin_oe;

    always_comb
    begin
        // Unclaimed pins: latch and direction alone
        nxt_pin_o  = latch_ff;
        nxt_pin_oe = ~dir_ff & pcm_pkg::LAT_DIR_MASK;
        if (osc_en)
        begin
            // Oscillator owns pins 0 and 1 whatever direction says
            nxt_pin_oe[pcm_pkg::PIN_OSC_OUT] = 1'b0;
            nxt_pin_oe[pcm_pkg::PIN_OSC_IN]  = 1'b0;
        end
        else if (usb_en && ext_xcvr)
        begin
            nxt_pin_o[pcm_pkg::PIN_OSC_IN] = XCVR_OE_N_I;
        end
        if (ccp_en)
            nxt_pin_o[pcm_pkg::PIN_CCP] = CCP_OUT_I;
        if (ser_async)
            nxt_pin_o[pcm_pkg::PIN_SER_TX] = SER_TX_I;
        else if (ser_syncm)
        begin
            nxt_pin_o[pcm_pkg::PIN_SER_TX]  = SER_CLK_OUT_I;
            nxt_pin_o[pcm_pkg::PIN_SER_RX]  = SER_DATA_OUT_I;
            nxt_pin_oe[pcm_pkg::PIN_SER_RX] = SER_DATA_OE_I;
        end
        // Port never drives 4 and 5; only the internal transceiver
        nxt_pin_o[pcm_pkg::PIN_DMINUS]  = USB_DM_OUT_I;
        nxt_pin_o[pcm_pkg::PIN_DPLUS]   = USB_DP_OUT_I;
        nxt_pin_oe[pcm_pkg::PIN_DMINUS] = usb_drive;
        nxt_pin_oe[pcm_pkg::PIN_DPLUS]  = usb_drive;
        nxt_pin_o[pcm_pkg::PIN_ABSENT]  = 1'b0;
        nxt_pin_oe[pcm_pkg::PIN_ABSENT] = 1'b0;
    end

    // ------------------------------------------------------------
    // Inputs towards peripherals and the pin-level register
    // ------------------------------------------------------------
    // A peripheral sees its pin only while it owns it; the timer alone
    // sees pin 0 whenever the oscillator is off, even as a port pin
    wire nxt_osc_enable  = osc_en;
    wire nxt_timer_count = pin_sync[pcm_pkg::PIN_OSC_OUT]
                         && !osc_en;
    wire nxt_ccp_capture = pin_sync[pcm_pkg::PIN_CCP] && ccp_en
                         && dir_ff[pcm_pkg::PIN_CCP];
    wire nxt_ser_rx      = pin_sync[pcm_pkg::PIN_SER_RX]
                         && ser_en;
    wire nxt_ser_clk_in  = pin_sync[pcm_pkg::PIN_SER_TX] && ser_syncm
                         && dir_ff[pcm_pkg::PIN_SER_TX];
    wire nxt_usb_dm_in   = pin_sync[pcm_pkg::PIN_DMINUS]
                         && usb_en;
    wire nxt_usb_dp_in   = pin_sync[pcm_pkg::PIN_DPLUS]
                         && usb_en;

    logic [7:0] levels;
    always_comb
    begin
        levels = pin_sync & pcm_pkg::PIN_LEVEL_MASK;
        if (osc_en)
        begin
            levels[pcm_pkg::PIN_OSC_OUT] = 1'b0;
            levels[pcm_pkg::PIN_OSC_IN]  = 1'b0;
        end
        if (!usb_pins_port)
        begin
            levels[pcm_pkg::PIN_DMINUS] = 1'b0;
            levels[pcm_pkg::PIN_DPLUS]  = 1'b0;
        end
    end

    wire [7:0] rd_sel =
        sel_pins  ? levels :
        sel_latch ? latch_ff :
        sel_dir   ? dir_ff :
        sel_usb   ? usb_ctrl_ff :
        sel_per   ? periph_ff : 8'h00;

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    always_ff @(posedge CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            latch_ff    <= pcm_pkg::LATCH_RESET;
            dir_ff      <= pcm_pkg::DIR_RESET;
            usb_ctrl_ff <= pcm_pkg::USB_CTRL_RESET;
            periph_ff   <= pcm_pkg::PERIPH_RESET;
        end
        else if (wr_en)
        begin
            // Writing the level register updates the latch
            if (sel_latch || sel_pins)
                latch_ff <= wdat & pcm_pkg::LAT_DIR_MASK;
            if (sel_dir)
                dir_ff <= wdat & pcm_pkg::LAT_DIR_MASK;
            if (sel_usb)
                usb_ctrl_ff <= wdat & pcm_pkg::USB_CTRL_MASK;
            if (sel_per)
                periph_ff <= wdat & pcm_pkg::PERIPH_MASK;
        end
    end

    // ------------------------------------------------------------
    // APB answer: one wait state, ready in the second access cycle
    // ------------------------------------------------------------
    always_ff @(posedge CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            rdata_ff  <= 32'h0000_0000;
            ready_ff  <= 1'b0;
            slverr_ff <= 1'b0;
        end
        else
        begin
            ready_ff  <= access && !ready_ff;
            slverr_ff <= access && !ready_ff && !mapped;
            // Captured in setup so the word is settled long before ready
            if (setup && !PWRITE_I)
                rdata_ff <= {24'h00_0000, rd_sel};
        end
    end

    // ------------------------------------------------------------
    // Output registers
    // ------------------------------------------------------------
    always_ff @(posedge CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            pin_o_ff  <= 8'h00;
            pin_oe_ff <= 8'h00;
            osc_enable_ff  <= 1'b0;
            timer_count_ff <= 1'b0;
            ccp_capture_ff <= 1'b0;
            ser_rx_ff      <= 1'b0;
            ser_clk_in_ff  <= 1'b0;
            usb_dm_in_ff   <= 1'b0;
            usb_dp_in_ff   <= 1'b0;
        end
        else
        begin
            pin_o_ff  <= nxt_pin_o;
            pin_oe_ff <= nxt_pin_oe;
            osc_enable_ff  <= nxt_osc_enable;
            timer_count_ff <= nxt_timer_count;
            ccp_capture_ff <= nxt_ccp_capture;
            ser_rx_ff      <= nxt_ser_rx;
            ser_clk_in_ff  <= nxt_ser_clk_in;
            usb_dm_in_ff   <= nxt_usb_dm_in;
            usb_dp_in_ff   <= nxt_usb_dp_in;
        end
    end

    assign PRDATA_O      = rdata_ff;
    assign PREADY_O      = ready_ff;
    assign PSLVERR_O     = slverr_ff;
    assign PIN_O         = pin_o_ff;
    assign PIN_OE_O      = pin_oe_ff;
    assign OSC_ENABLE_O  = osc_enable_ff;
    assign TIMER_COUNT_O = timer_count_ff;
    assign CCP_CAPTURE_O = ccp_capture_ff;
    assign SER_RX_O      = ser_rx_ff;
    assign SER_CLK_IN_O  = ser_clk_in_ff;
    assign USB_DM_IN_O   = usb_dm_in_ff;
    assign USB_DP_IN_O   = usb_dp_in_ff;

endmodule

// [testbench/pcm_port_c_props.sv]
`timescale 1ns/1ps
module pcm_port_c_props (
    // Clock and reset
    input  wire logic        CLK_I,
    input  wire logic        RST_N_I,
    // Bus
    input  wire logic        PSEL_I,
    input  wire logic        PENABLE_I,
    input  wire logic        PWRITE_I,
    input  wire logic [31:0] PRDATA_O,
    input  wire logic        PREADY_O,
    input  wire logic        PSLVERR_O,
    // Pins
    input  wire logic [7:0]  PIN_OE_O,
    input  wire logic        USB_DRIVE_I,
    input  wire logic        OSC_ENABLE_O
);
    // ------------
    // Properties
    // ------------
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (!RST_N_I);

    sequence setup_s;
        PSEL_I && !PENABLE_I;
    endsequence
    sequence answer_s;
        PSEL_I && PENABLE_I ##1 PREADY_O;
    endsequence

    ready_after_setup_a: assert property (setup_s |=> answer_s)
        else $error("no ready one wait state after setup");
    ready_pulse_a: assert property (PREADY_O |=> !PREADY_O)
        else $error("ready held longer than one cycle");
    ready_in_access_a: assert property (
        PREADY_O |-> PSEL_I && PENABLE_I)
        else $error("ready outside an access phase");
    error_with_ready_a: assert property (PSLVERR_O |-> PREADY_O)
        else $error("error response without ready");
    error_reads_zero_a: assert property (
        PSLVERR_O && !PWRITE_I |-> PRDATA_O == 32'h0)
        else $error("unmapped read returned data");
    upper_zero_a: assert property (
        PREADY_O && !PWRITE_I |-> PRDATA_O[31:8] == 24'h0)
        else $error("upper read bits not zero");
    usb_drive_gate_a: assert property (
        |PIN_OE_O[5:3] |-> $past(USB_DRIVE_I) && !PIN_OE_O[3])
        else $error("pins 3 to 5 driven without transceiver drive");
    osc_frees_pins_a: assert property (
        OSC_ENABLE_O && $past(OSC_ENABLE_O) |-> PIN_OE_O[1:0] == 2'b00)
        else $error("oscillator pins still driven");
endmodule

bind pcm_port_c pcm_port_c_props pcm_port_c_props_i (
    .CLK_I(CLK_I), .RST_N_I(RST_N_I), .PSEL_I(PSEL_I),
    .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PRDATA_O(PRDATA_O),
    .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .PIN_OE_O(PIN_OE_O),
    .USB_DRIVE_I(USB_DRIVE_I), .OSC_ENABLE_O(OSC_ENABLE_O)
);

// [testbench/pcm_pin_partner.sv]
`timescale 1ns/1ps
module pcm_pin_partner (
    // Clock
    input  wire logic       clk_i,
    // Device side
    input  wire logic [7:0] pin_o_i,
    input  wire logic [7:0] pin_oe_i,
    // Bench control
    input  wire logic [7:0] ext_en_i,
    input  wire logic [7:0] ext_val_i,
    output logic      [7:0] pin_i_o
);
    // Released pins toggle so a stale value can never pass for a read
    logic [7:0] float_ff = 8'h5a;

    always_ff @(posedge clk_i)
        float_ff <= ~float_ff;

    assign pin_i_o = (pin_oe_i & pin_o_i)
                   | (~pin_oe_i & ext_en_i & ext_val_i)
                   | (~pin_oe_i & ~ext_en_i & float_ff);
endmodule

// [testbench/pcm_port_c_tb_top.sv]
`timescale 1ns/1ps
module pcm_port_c_tb_top;
    // ------------
    // Wiring
    // ------------
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        psel = 1'b0;
    logic        pen = 1'b0;
    logic        pwr = 1'b0;
    logic [7:0]  padr = 8'h00;
    logic [31:0] pwd = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [7:0]  pin_i;
    logic [7:0]  pin_o;
    logic [7:0]  pin_oe;
    logic [8:0]  pi = 9'h000;
    logic [6:0]  po;
    logic [7:0]  ext_en = 8'hff;
    logic [7:0]  ext_val = 8'h00;
    logic [31:0] rd;
    logic        lerr;
    int          err_total = 0;
    int          total_checks = 0;

    always #4 clk = ~clk;

    pcm_port_c pcm_port_c_i (
        .CLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen),
        .PWRITE_I(pwr), .PADDR_I(padr), .PWDATA_I(pwd),
        .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
        .PIN_I(pin_i), .PIN_O(pin_o), .PIN_OE_O(pin_oe),
        .CCP_OUT_I(pi[0]), .SER_TX_I(pi[1]), .SER_CLK_OUT_I(pi[2]),
        .SER_DATA_OUT_I(pi[3]), .SER_DATA_OE_I(pi[4]),
        .XCVR_OE_N_I(pi[5]), .USB_DM_OUT_I(pi[6]), .USB_DP_OUT_I(pi[7]),
        .USB_DRIVE_I(pi[8]), .OSC_ENABLE_O(po[0]), .TIMER_COUNT_O(po[1]),
        .CCP_CAPTURE_O(po[2]), .SER_RX_O(po[3]), .SER_CLK_IN_O(po[4]),
        .USB_DM_IN_O(po[5]), .USB_DP_IN_O(po[6])
    );

    pcm_pin_partner pcm_pin_partner_i (
        .clk_i(clk), .pin_o_i(pin_o), .pin_oe_i(pin_oe),
        .ext_en_i(ext_en), .ext_val_i(ext_val), .pin_i_o(pin_i)
    );

    // ------------
    // Helpers
    // ------------
    task end_of_test;
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task chk(input string n, input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e)
        begin
            err_total++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwr <= w;
        padr <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        // No limit here: the watchdog ends a hung transfer
        while (pready !== 1'b1)
            @(posedge clk);
        rd = prdata;
        lerr = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask

    task wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d});
    endtask

    task rdx(input logic [7:0] a, input logic [31:0] e, input string n);
        apb(1'b0, a, 32'h0);
        chk(n, rd, e);
    endtask

    // Pins settle within four edges of a write or an external change
    task cfg(input logic [7:0] p, input logic [7:0] d, input logic [7:0] l);
        wr(pcm_pkg::ADDR_PERIPH, p);
        wr(pcm_pkg::ADDR_DIRECTION, d);
        wr(pcm_pkg::ADDR_LATCH, l);
        repeat (4) @(posedge clk);
    endtask

    // ------------
    // Scenarios
    // ------------
    task t_reset;
        rdx(pcm_pkg::ADDR_LATCH, 32'h0, "latch");
        rdx(pcm_pkg::ADDR_DIRECTION, 32'hc7, "dir");
        rdx(pcm_pkg::ADDR_USB_CTRL, 32'h0, "usb");
        rdx(pcm_pkg::ADDR_PERIPH, 32'h08, "per");
        chk("oe", pin_oe, 32'h0);
    endtask

    task t_port;
        ext_val <= 8'h30;
        // Pin 3 floats from here on: it must never read back
        ext_en <= 8'hf7;
        cfg(8'h08, 8'h00, 8'hff);
        chk("oe", pin_oe, 32'hc7);
        chk("out", pin_o & pin_oe, 32'hc7);
        rdx(pcm_pkg::ADDR_LATCH, 32'hc7, "latch");
        rdx(pcm_pkg::ADDR_PIN_LEVELS, 32'hf7, "lvl");
        ext_val <= 8'hac;
        wr(pcm_pkg::ADDR_DIRECTION, 8'hff);
        repeat (4) @(posedge clk);
        rdx(pcm_pkg::ADDR_DIRECTION, 32'hc7, "dir");
        rdx(pcm_pkg::ADDR_PIN_LEVELS, 32'ha4, "lvl");
        rdx(pcm_pkg::ADDR_LATCH, 32'hc7, "latch");
        wr(pcm_pkg::ADDR_PIN_LEVELS, 8'h41);
        apb(1'b1, 8'h14, 32'hff);
        chk("werr", lerr, 32'h1);
        rdx(pcm_pkg::ADDR_LATCH, 32'h41, "latch");
        rdx(8'h14, 32'h0, "unmapped");
        chk("rerr", lerr, 32'h1);
    endtask

    task t_usb;
        ext_val <= 8'h30;
        wr(pcm_pkg::ADDR_USB_CTRL, 8'hff);
        cfg(8'h00, 8'h00, 8'h00);
        rdx(pcm_pkg::ADDR_USB_CTRL, 32'h7e, "usb");
        rdx(pcm_pkg::ADDR_PIN_LEVELS, 32'h0, "lvl");
        chk("usbin", po[6:5], 32'h3);
        pi <= 9'h140;
        repeat (2) @(posedge clk);
        chk("usboe", pin_oe[5:4], 32'h3);
        chk("usbout", pin_o[5:4], 32'h1);
        pi <= 9'h020;
        ext_val <= 8'h10;
        cfg(8'h04, 8'h00, 8'h00);
        chk("extoe", pin_oe[5:4], 32'h0);
        chk("extin", po[6:5], 32'h1);
        chk("xoe", {pin_oe[1], pin_o[1]}, 32'h3);
        wr(pcm_pkg::ADDR_USB_CTRL, 8'h00);
        pi <= 9'h000;
    endtask

    task t_osc;
        ext_val <= 8'hff;
        cfg(8'h01, 8'h00, 8'h03);
        chk("osc", {po[0], pin_oe[1:0]}, 32'h4);
        chk("tmr", po[1], 32'h0);
        rdx(pcm_pkg::ADDR_PIN_LEVELS, 32'h0, "lvl");
        wr(pcm_pkg::ADDR_PERIPH, 8'h00);
        repeat (4) @(posedge clk);
        chk("tmr", po[1], 32'h1);
    endtask

    task t_ccp;
        pi <= 9'h001;
        cfg(8'h02, 8'h00, 8'h00);
        chk("cmp", pin_o[2], 32'h1);
        wr(pcm_pkg::ADDR_DIRECTION, 8'h04);
        repeat (4) @(posedge clk);
        chk("cap", po[2], 32'h1);
        ext_val <= 8'h00;
        repeat (4) @(posedge clk);
        chk("cap", po[2], 32'h0);
    endtask

    task t_serial;
        pi <= 9'h002;
        ext_val <= 8'h80;
        cfg(8'h10, 8'h80, 8'h00);
        chk("tx", {pin_oe[6], pin_o[6]}, 32'h3);
        chk("rx", po[3], 32'h1);
        pi <= 9'h01c;
        ext_val <= 8'h40;
        cfg(8'h30, 8'h40, 8'h00);
        chk("ckin", po[4], 32'h1);
        chk("dt", {pin_oe[7], pin_o[7]}, 32'h3);
        pi <= 9'h004;
        wr(pcm_pkg::ADDR_DIRECTION, 8'h80);
        repeat (4) @(posedge clk);
        chk("ckout", {pin_oe[6], pin_o[6]}, 32'h3);
        chk("dtin", pin_oe[7], 32'h0);
    endtask

    initial
    begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_reset;
        t_port;
        t_usb;
        t_osc;
        t_ccp;
        t_serial;
        end_of_test;
    end

    initial
    begin
        #100000;
        err_total++;
        end_of_test;
    end
endmodule
